// ---- dv/usbts_core_test.sv ----
// self-checking bench for usbts_core with a queue-based reference model
// assumes usbts_host drives the link side; tasks drive the register port
`timescale 1ns/100ps

module usbts_core_test;
    import usbts_pkg::*;
    logic            i_sys_clk, i_srst, wr, rd, tv, xd, ss;
    logic            rv, ra, rn, rs, rz, flag;
    logic [3:0]      addr;
    logic [7:0]      wdata, rdata;
    logic [2:0]      tep, sep;
    usbts_token_type tkind;
    usbts_entry_type xe, e;
    int              bad_count, checked;
    logic [4:0]      ctl [8];
    logic [4:0]      q [$];

    usbts_core i_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_tok_valid(tv), .i_tok_ep(tep), .i_tok_kind(tkind), .i_xfer_done(xd),
        .i_xfer_entry(xe), .i_stall_sent(ss), .i_stall_ep(sep), .o_resp_valid(rv),
        .o_resp_ack(ra), .o_resp_nak(rn), .o_resp_stall(rs), .o_resp_none(rz),
        .o_transfer_done_flag(flag));
    usbts_host i_host (.i_sys_clk(i_sys_clk), .o_tok_valid(tv), .o_tok_ep(tep),
        .o_tok_kind(tkind), .o_xfer_done(xd), .o_xfer_entry(xe),
        .o_stall_sent(ss), .o_stall_ep(sep));

    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    // =========================================
    // shared tasks
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] sn);
        checked++;
        if (sn !== ex) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, sn);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [7:0] ex, input string nm);
        @(posedge i_sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_sys_clk);
        rd <= 1'b0;
        #1;
        chk(nm, ex, rdata);
    endtask : rchk

    // reference: {valid, ack, nak, stall, none}
    function automatic logic [4:0] exp_resp(input logic [4:0] c, input int k, input bit full);
        logic en;
        en = (k == 1) ? c[1] : (k == 0) ? c[2] : (c[2] & ~c[3]);
        if (!en || !c[4]) return 5'h11;
        if (c[0]) return 5'h12;
        if (full) return 5'h14;
        return 5'h18;
    endfunction : exp_resp

    task automatic tok(input logic [2:0] ep, input int k, input bit full);
        i_host.token(ep, k);
        #1;
        chk("response", {3'h0, exp_resp(ctl[ep], k, full)}, {3'h0, rv, ra, rn, rs, rz});
    endtask : tok

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    // tests need about 500 cycles; cut off at 20000
    initial begin
        #(20 * 20000);
        bad_count++;
        conclude();
    end

    // =========================================
    // main sequence
    initial begin
        logic [4:0] c;
        int         ep;
        i_srst = 1'b1;
        {addr, wdata, wr, rd, bad_count, checked} = '0;
        void'($urandom(65691));
        repeat (3) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        for (int n = 0; n < 8; n++) begin
            rchk(4'(n), 8'h00, "control reset");
            ctl[n] = 5'h00;
        end
        rchk(4'hA, 8'h00, "unmapped");
        for (int n = 0; n < 48; n++) begin
            ep = $urandom_range(7);
            c  = 5'($urandom) & 5'h1E;
            if (ep == 0) c[3] = 1'b0;
            wr_reg(4'(ep), {3'h7, c});
            ctl[ep] = c;
            if ($urandom_range(1) == 1) begin
                i_host.stall(3'(ep));
                ctl[ep][0] = 1'b1;
            end
            rchk(4'(ep), {3'h0, ctl[ep]}, "control");
            tok(3'(ep), $urandom_range(2), 1'b0);
        end
        // engine stall and firmware clear in one cycle: the stall wins
        fork
            wr_reg(4'h2, 8'h00);
            i_host.stall(3'h2);
        join
        ctl[2] = 5'h01;
        rchk(4'h2, 8'h01, "stall beats clear");
        // five completions into four places; the fifth is lost while full
        wr_reg(4'h1, 8'h16);
        ctl[1] = 5'h16;
        for (int n = 0; n < 5; n++) begin
            e = usbts_entry_type'(5'($urandom));
            i_host.done(e);
            if (q.size() < FIFO_DEPTH) q.push_back(e);
            if (n == 0) tok(3'h1, 1, 1'b0);
        end
        tok(3'h1, 0, 1'b1);
        while (q.size() > 0) begin
            repeat (3) @(posedge i_sys_clk);
            #1;
            chk("done flag", 8'h01, {7'h0, flag});
            e = q.pop_front();
            rchk(ADDR_XFER_STATUS, {2'b00, e, 1'b0}, "status");
            rchk(ADDR_FLAG_CTRL, 8'h01, "flag reg");
            wr_reg(ADDR_FLAG_CTRL, 8'h01);
            rchk(ADDR_XFER_STATUS, 8'h00, "stale status");
        end
        repeat (REASSERT_MAX_CLK) @(posedge i_sys_clk);
        #1;
        chk("done flag", 8'h00, {7'h0, flag});
        // a clear with the flag low is ignored; the entry after the wrap still shows
        wr_reg(ADDR_FLAG_CTRL, 8'h01);
        e = usbts_entry_type'(5'($urandom));
        // reset in mid-run with a pending entry and set controls
        wr_reg(4'h3, 8'h1F);
        i_host.done(e);
        repeat (3) @(posedge i_sys_clk);
        rchk(ADDR_XFER_STATUS, {2'b00, e, 1'b0}, "status after wrap");
        @(posedge i_sys_clk);
        i_srst <= 1'b1;
        @(posedge i_sys_clk);
        i_srst <= 1'b0;
        rchk(4'h3, 8'h00, "control after reset");
        rchk(ADDR_XFER_STATUS, 8'h00, "status after reset");
        chk("done flag", 8'h00, {7'h0, flag});
        conclude();
    end
endmodule : usbts_core_test

// ---- dv/usbts_host.sv ----
// host-side packet engine model: tokens, buffer completions, stalls
// assumes the bench calls its tasks; the core samples on rising edges
`timescale 1ns/100ps

module usbts_host
    import usbts_pkg::*;
(
    input  wire logic       i_sys_clk,
    output logic            o_tok_valid,
    output logic [2:0]      o_tok_ep,
    output usbts_token_type o_tok_kind,
    output logic            o_xfer_done,
    output usbts_entry_type o_xfer_entry,
    output logic            o_stall_sent,
    output logic [2:0]      o_stall_ep
);
    initial begin
        o_tok_valid  = 1'b0;
        o_tok_ep     = 3'h0;
        o_tok_kind   = USBTS_TOK_OUT;
        o_xfer_done  = 1'b0;
        o_xfer_entry = '0;
        o_stall_sent = 1'b0;
        o_stall_ep   = 3'h0;
    end

    // =========================================
    // one-cycle pulses; ep and entry qualifiers flip after (token kind holds) so stale values never pass
    task automatic token(input logic [2:0] ep, input int kind);
        @(posedge i_sys_clk);
        o_tok_valid <= 1'b1;
        o_tok_ep    <= ep;
        o_tok_kind  <= usbts_token_type'(kind);
        @(posedge i_sys_clk);
        o_tok_valid <= 1'b0;
        o_tok_ep    <= ~ep;
    endtask : token

    task automatic done(input usbts_entry_type e);
        @(posedge i_sys_clk);
        o_xfer_done  <= 1'b1;
        o_xfer_entry <= e;
        @(posedge i_sys_clk);
        o_xfer_done  <= 1'b0;
        o_xfer_entry <= ~e;
    endtask : done

    task automatic stall(input logic [2:0] ep);
        @(posedge i_sys_clk);
        o_stall_sent <= 1'b1;
        o_stall_ep   <= ep;
        @(posedge i_sys_clk);
        o_stall_sent <= 1'b0;
        o_stall_ep   <= ~ep;
    endtask : stall
endmodule : usbts_host

// ---- hdl/usbts_core.sv ----
// transfer status fifo and endpoint control registers of the serial engine
// assumes the packet engine gives one-cycle token and completion pulses
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps

module usbts_core
    import usbts_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_srst,
    input  wire logic [3:0]        i_reg_addr,
    input  wire logic [7:0]        i_reg_wdata,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    output logic      [7:0]        o_reg_rdata,
    input  wire logic              i_tok_valid,
    input  wire logic [2:0]        i_tok_ep,
    input  wire usbts_token_type   i_tok_kind,
    input  wire logic              i_xfer_done,
    input  wire usbts_entry_type   i_xfer_entry,
    input  wire logic              i_stall_sent,
    input  wire logic [2:0]        i_stall_ep,
    output logic                   o_resp_valid,
    output logic                   o_resp_ack,
    output logic                   o_resp_nak,
    output logic                   o_resp_stall,
    output logic                   o_resp_none,
    output logic                   o_transfer_done_flag
);

    // ==================================================================
    // endpoint control registers
    logic [4:0] ctl_q [NUM_EP];
    logic [4:0] ctl_d [NUM_EP];

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            always_comb begin
                ctl_d[g] = ctl_q[g];
                if (i_reg_wr && i_reg_addr == ADDR_EP_CTRL_BASE + 4'(g)) begin
                    ctl_d[g] = i_reg_wdata[4:0];
                end
                // set wins over a firmware clear in the same cycle
                if (i_stall_sent && i_stall_ep == 3'(g)) begin
                    ctl_d[g][CTL_STALL_BIT] = 1'b1;
                end
            end
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    ctl_q[g] <= CTL_RESET;
                end else begin
                    ctl_q[g] <= ctl_d[g];
                end
            end
            ctl_write_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                (i_reg_wr && i_reg_addr == ADDR_EP_CTRL_BASE + 4'(g)
                 && !(i_stall_sent && i_stall_ep == 3'(g)))
                |=> ctl_q[g] == $past(i_reg_wdata[4:0]))
                else $error("control write lost");
            stall_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
                (ctl_q[g][CTL_STALL_BIT] && !(i_reg_wr && i_reg_addr == ADDR_EP_CTRL_BASE + 4'(g)))
                |=> ctl_q[g][CTL_STALL_BIT])
                else $error("stall bit dropped without a write");
        end
    endgenerate

    // ==================================================================
    // status fifo
    usbts_entry_type fifo_q [FIFO_DEPTH];
    usbts_entry_type fifo_d [FIFO_DEPTH];
    logic [1:0] rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
    logic [2:0] count_q, count_d;
    logic       flag_q, flag_d;
    logic [1:0] age_q, age_d;        // clocks since the head became visible
    logic       pop, push;

    assign pop  = i_reg_wr && i_reg_addr == ADDR_FLAG_CTRL && i_reg_wdata[0] && flag_q;
    // completions that arrive while full are dropped, not queued
    assign push = i_xfer_done && count_q != 3'(FIFO_DEPTH);

    always_comb begin
        fifo_d   = fifo_q;
        rd_ptr_d = rd_ptr_q;
        wr_ptr_d = wr_ptr_q;
        count_d  = count_q;
        if (push) begin
            fifo_d[wr_ptr_q] = i_xfer_entry;
            wr_ptr_d         = wr_ptr_q + 2'h1;
        end
        if (pop) begin
            rd_ptr_d = rd_ptr_q + 2'h1;
        end
        count_d = count_q + 3'(push) - 3'(pop);
        // flag follows fifo occupancy, one clock after a pop the next head raises it
        flag_d = pop ? 1'b0 : (count_q != 3'h0);
        age_d  = (pop || count_q == 3'h0) ? 2'h0
               : (age_q == 2'h3 ? age_q : age_q + 2'h1);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rd_ptr_q <= 2'h0;
            wr_ptr_q <= 2'h0;
            count_q  <= 3'h0;
            flag_q   <= 1'b0;
            age_q    <= 2'h0;
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                fifo_q[i] <= '0;
            end
        end else begin
            rd_ptr_q <= rd_ptr_d;
            wr_ptr_q <= wr_ptr_d;
            count_q  <= count_d;
            flag_q   <= flag_d;
            age_q    <= age_d;
            fifo_q   <= fifo_d;
        end
    end

    // ==================================================================
    // token response
    logic [4:0] tctl;
    logic       t_allowed, t_full;
    logic       r_valid_d, r_ack_d, r_nak_d, r_stall_d, r_none_d;
    logic       r_valid_q, r_ack_q, r_nak_q, r_stall_q, r_none_q;

    always_comb begin
        tctl   = ctl_q[i_tok_ep];
        t_full = count_q == 3'(FIFO_DEPTH);
        case (i_tok_kind)
            USBTS_TOK_OUT:   t_allowed = tctl[CTL_OUT_BIT];
            USBTS_TOK_IN:    t_allowed = tctl[CTL_IN_BIT];
            USBTS_TOK_SETUP: t_allowed = !tctl[CTL_SETUP_BIT]
                                         && tctl[CTL_OUT_BIT];
            default:         t_allowed = 1'b0;
        endcase
        r_valid_d = i_tok_valid;
        r_ack_d   = 1'b0;
        r_nak_d   = 1'b0;
        r_stall_d = 1'b0;
        r_none_d  = 1'b0;
        if (i_tok_valid) begin
            if (!t_allowed || !tctl[CTL_HSHK_BIT]) begin
                r_none_d = 1'b1;
            end else if (tctl[CTL_STALL_BIT]) begin
                r_stall_d = 1'b1;
            end else if (t_full) begin
                r_nak_d = 1'b1;
            end else begin
                r_ack_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            r_valid_q <= 1'b0;
            r_ack_q   <= 1'b0;
            r_nak_q   <= 1'b0;
            r_stall_q <= 1'b0;
            r_none_q  <= 1'b0;
        end else begin
            r_valid_q <= r_valid_d;
            r_ack_q   <= r_ack_d;
            r_nak_q   <= r_nak_d;
            r_stall_q <= r_stall_d;
            r_none_q  <= r_none_d;
        end
    end

    // ==================================================================
    // register read
    logic [7:0] rdata_d, rdata_q;
    usbts_entry_type head;

    always_comb begin
        head    = fifo_q[rd_ptr_q];
        rdata_d = 8'h00;
        if (i_reg_rd) begin
            if (i_reg_addr < ADDR_XFER_STATUS) begin
                rdata_d = {3'h0, ctl_q[i_reg_addr[2:0]]};
            end else if (i_reg_addr == ADDR_XFER_STATUS) begin
                // head entry is stale until one clock after the flag rose
                if (age_q >= 2'(VALID_DELAY_CLKS)) begin
                    rdata_d[STS_EP_LSB +: 3] = head.ep;
                    rdata_d[STS_DIR_BIT]     = head.dir_in;
                    rdata_d[STS_BANK_BIT]    = head.bank_odd;
                end
            end else if (i_reg_addr == ADDR_FLAG_CTRL) begin
                rdata_d = {7'h00, flag_q};
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_reg_rdata          = rdata_q;
    assign o_transfer_done_flag = flag_q;
    assign o_resp_valid         = r_valid_q;
    assign o_resp_ack           = r_ack_q;
    assign o_resp_nak           = r_nak_q;
    assign o_resp_stall         = r_stall_q;
    assign o_resp_none          = r_none_q;

    // ==================================================================
    // clocks spent waiting for the flag while entries are queued
    logic [5:0] wait_q, wait_d;

    always_comb begin
        wait_d = 6'h00;
        if (!flag_q && count_q != 3'h0) begin
            wait_d = (wait_q == 6'h3F) ? wait_q : wait_q + 6'h01;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wait_q <= 6'h00;
        end else begin
            wait_q <= wait_d;
        end
    end

    // ==================================================================
    // checks
    flag_reassert_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (pop && count_q > 3'h1) |=> ##[0:4] o_transfer_done_flag)
        else $error("flag not raised again with entries queued");
    flag_low_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (pop && count_q == 3'h1 && !push) |=> !o_transfer_done_flag [*2])
        else $error("flag raised with empty fifo");
    full_nak_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_tok_valid && t_full && t_allowed && tctl[CTL_HSHK_BIT] && !tctl[CTL_STALL_BIT])
        |=> o_resp_nak)
        else $error("full fifo did not nak");
    stall_set_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_stall_sent |=> ctl_q[$past(i_stall_ep)][CTL_STALL_BIT])
        else $error("stall bit not set");
    no_hshk_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_tok_valid && !tctl[CTL_HSHK_BIT]) |=> (o_resp_none && !o_resp_ack))
        else $error("handshake sent while disabled");
    setup_block_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_tok_valid && i_tok_kind == USBTS_TOK_SETUP && tctl[CTL_SETUP_BIT]) |=> o_resp_none)
        else $error("setup accepted while disabled");
    count_track_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (push && !pop) |=> count_q == $past(count_q) + 3'h1)
        else $error("push not counted");
    stale_read_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == ADDR_XFER_STATUS && age_q < 2'h2) |=> o_reg_rdata == 8'h00)
        else $error("window read before valid");
    pad_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == ADDR_XFER_STATUS)
        |=> (o_reg_rdata[7:6] == 2'h0 && o_reg_rdata[0] == 1'b0))
        else $error("unused status bits not zero");

    // ==================================================================
    // checks on the token answer
    resp_onehot_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_resp_valid |-> $onehot({o_resp_ack, o_resp_nak, o_resp_stall, o_resp_none}))
        else $error("token answer not exactly one kind");
    out_block_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_tok_valid && i_tok_kind == USBTS_TOK_OUT && !tctl[CTL_OUT_BIT]) |=> o_resp_none)
        else $error("out accepted while disabled");
    in_block_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_tok_valid && i_tok_kind == USBTS_TOK_IN && !tctl[CTL_IN_BIT]) |=> o_resp_none)
        else $error("in accepted while disabled");
    stall_ignored_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_tok_valid && !t_allowed) |=> !o_resp_stall)
        else $error("stall answered on disabled endpoint");
    stall_answer_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_tok_valid && t_allowed && tctl[CTL_HSHK_BIT] && tctl[CTL_STALL_BIT])
        |=> o_resp_stall)
        else $error("stalled endpoint not stalled");
    ack_answer_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_tok_valid && t_allowed && tctl[CTL_HSHK_BIT] && !tctl[CTL_STALL_BIT] && !t_full)
        |=> o_resp_ack)
        else $error("enabled endpoint not acknowledged");

    // ==================================================================
    // checks on the status fifo
    count_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        count_q <= 3'(FIFO_DEPTH))
        else $error("fifo count above depth");
    full_drop_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_xfer_done && t_full && !pop) |=> count_q == 3'(FIFO_DEPTH))
        else $error("completion taken while full");
    queue_order_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        push |=> fifo_q[$past(wr_ptr_q)] == $past(i_xfer_entry))
        else $error("completion not queued at tail");
    pop_advance_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        pop |=> (rd_ptr_q == $past(rd_ptr_q) + 2'h1 && !o_transfer_done_flag))
        else $error("clear did not advance the fifo");
    flag_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_transfer_done_flag |-> count_q != 3'h0)
        else $error("flag high with empty fifo");
    flag_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        wait_q < 6'(REASSERT_MAX_CLK))
        else $error("flag not raised again in time");

    // ==================================================================
    // checks on the register read path
    window_late_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_transfer_done_flag) |-> age_q < 2'(VALID_DELAY_CLKS))
        else $error("window valid as the flag rose");
    ep_field_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == ADDR_XFER_STATUS && age_q >= 2'(VALID_DELAY_CLKS))
        |=> o_reg_rdata[STS_EP_LSB +: 3] == $past(head.ep))
        else $error("endpoint field wrong");
    dir_field_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == ADDR_XFER_STATUS && age_q >= 2'(VALID_DELAY_CLKS))
        |=> o_reg_rdata[STS_DIR_BIT] == $past(head.dir_in))
        else $error("direction field wrong");
    bank_field_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == ADDR_XFER_STATUS && age_q >= 2'(VALID_DELAY_CLKS))
        |=> o_reg_rdata[STS_BANK_BIT] == $past(head.bank_odd))
        else $error("bank field wrong");
    ctl_pad_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_reg_rd && i_reg_addr < ADDR_XFER_STATUS) |=> o_reg_rdata[7:5] == 3'h0)
        else $error("unused control bits not zero");
    idle_read_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !i_reg_rd |=> o_reg_rdata == 8'h00)
        else $error("read data without a read");

    fill_c:  cover property (@(posedge i_sys_clk) count_q == 3'h4);
    nak_c:   cover property (@(posedge i_sys_clk) o_resp_nak);
    pop_c:   cover property (@(posedge i_sys_clk) pop && count_q > 3'h1);
    stall_c: cover property (@(posedge i_sys_clk) o_resp_stall);
    stale_c: cover property (@(posedge i_sys_clk)
        i_reg_rd && i_reg_addr == ADDR_XFER_STATUS && age_q < 2'h2);

endmodule : usbts_core

// ---- hdl/usbts_pkg.sv ----
// package for the usb transfer status and endpoint control block
// assumes one 50 MHz engine clock and a plain register port
package usbts_pkg;

    // ==================================================================
    // register map
    localparam logic [3:0] ADDR_EP_CTRL_BASE = 4'h0;  // eight control regs at 0..7
    localparam logic [3:0] ADDR_XFER_STATUS  = 4'h8;
    localparam logic [3:0] ADDR_FLAG_CTRL    = 4'h9;  // bit0 done flag, write 1 clears
    localparam int         NUM_EP            = 8;
    localparam int         FIFO_DEPTH        = 4;

    // ==================================================================
    // field positions
    localparam int CTL_HSHK_BIT  = 4;
    localparam int CTL_SETUP_BIT = 3;
    localparam int CTL_OUT_BIT   = 2;
    localparam int CTL_IN_BIT    = 1;
    localparam int CTL_STALL_BIT = 0;
    localparam int STS_EP_LSB    = 3;
    localparam int STS_DIR_BIT   = 2;
    localparam int STS_BANK_BIT  = 1;
    localparam logic [4:0] CTL_RESET = 5'h00;

    // ==================================================================
    // timing
    localparam int CLK_MHZ          = 50;
    localparam int VALID_DELAY_CLKS = 2;   // window valid one clock after flag
    localparam int REASSERT_MAX_NS  = 6 * 83; // six instruction cycles at 12 MIPS
    localparam int REASSERT_MAX_CLK = (REASSERT_MAX_NS * CLK_MHZ) / 1000;

    typedef struct packed {
        logic [2:0] ep;
        logic       dir_in;
        logic       bank_odd;
    } usbts_entry_type;

    typedef enum logic [1:0] {
        USBTS_TOK_OUT,
        USBTS_TOK_IN,
        USBTS_TOK_SETUP
    } usbts_token_type;

endpackage : usbts_pkg
